//--- verilog/smwc_pkg.sv
package smwc_pkg;
  // warm-up exponents, in periods of the post-wake clock
  localparam int WARM_SHORT_EXP = 14;
  localparam int WARM_LONG_EXP  = 16;
  localparam int FAST_WARM_EXP  = 4;  // shortened warm-up for an external stable clock
  localparam int WARM_CNT_W     = 17;
  localparam logic [WARM_CNT_W-1:0] WARM_SHORT_CNT = 17'h04000;
  localparam logic [WARM_CNT_W-1:0] WARM_LONG_CNT  = 17'h10000;
  localparam logic [WARM_CNT_W-1:0] WARM_FAST_CNT  = 17'h00010;
  // halt instruction execution, in states
  localparam logic [3:0] HALT_EXEC_STATES = 4'h8;
  // transition into stop after halt execution
  localparam logic [1:0] ENTRY_CLOCKS     = 2'h3;
  localparam int PORT_W = 8;

  typedef enum logic [4:0] {
    SMWC_RUN    = 5'h01,
    SMWC_HALT   = 5'h02,
    SMWC_ENTRY  = 5'h04,
    SMWC_STOP   = 5'h08,
    SMWC_WARM   = 5'h10
  } smwc_state_t;

  typedef struct packed {
    logic drive_enable;
    logic warm_select;
    logic fast_warmup_select;
    logic return_clock_select;
    logic main_osc_return_enable;
    logic sub_osc_return_enable;
  } smwc_cfg_t;

  typedef struct packed {
    logic osc_main_en;
    logic osc_sub_en;
    logic sys_clk_en;
    logic slow_mode;
  } smwc_clk_t;
endpackage

//--- verilog/smwc_warm_counter.sv
`timescale 1ns/1ps
`default_nettype none
module smwc_warm_counter (
  input  wire logic                             ref_clk,
  input  wire logic                             rst_n,
  input  wire logic                             start,
  input  wire logic [smwc_pkg::WARM_CNT_W-1:0]  limit,
  output logic                                  done
);
  logic [smwc_pkg::WARM_CNT_W-1:0] cnt_q;
  logic                            run_q;

  // counts limit cycles after start, then pulses done
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= limit - 17'h00001;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 17'h00001;
        end
      end
    end
  end
endmodule // smwc_warm_counter
`default_nettype wire

//--- verilog/smwc_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module smwc_pin_ctrl (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         stopped,
  input  wire logic                         drive_enable,
  input  wire logic [smwc_pkg::PORT_W-1:0]  port_out,
  input  wire logic [smwc_pkg::PORT_W-1:0]  port_oe,
  input  wire logic                         ale_run,
  input  wire logic                         clk_run,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_out,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_oe,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_in_gate,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_pull_en,
  output logic                              ale_out,
  output logic                              clkout_out,
  output logic                              clkout_oe,
  output logic                              xtal_out
);
  // per-pin stop behaviour: drive kept, or floated with pull and gate off
  for (genvar i = 0; i < smwc_pkg::PORT_W; i++) begin : g_pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_out[i]     <= 1'b0;
        pin_oe[i]      <= 1'b0;
        pin_in_gate[i] <= 1'b1;
        pin_pull_en[i] <= 1'b0;
      end else if (stopped && !drive_enable) begin
        pin_out[i]     <= 1'b0;
        pin_oe[i]      <= 1'b0;
        pin_in_gate[i] <= 1'b0;
        pin_pull_en[i] <= 1'b1;
      end else begin
        pin_out[i]     <= port_out[i];
        pin_oe[i]      <= port_oe[i];
        pin_in_gate[i] <= 1'b1;
        pin_pull_en[i] <= 1'b0;
      end
    end
  end

  // bus-control and crystal pins during stop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_out    <= 1'b0;
      clkout_out <= 1'b0;
      clkout_oe  <= 1'b1;
      xtal_out   <= 1'b0;
    end else if (stopped) begin
      ale_out    <= 1'b0;
      clkout_out <= 1'b1;
      clkout_oe  <= drive_enable;
      xtal_out   <= 1'b1;
    end else begin
      ale_out    <= ale_run;
      clkout_out <= clk_run;
      clkout_oe  <= 1'b1;
      xtal_out   <= 1'b0;
    end
  end
endmodule // smwc_pin_ctrl
`default_nettype wire

//--- verilog/smwc_stop_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module smwc_stop_ctrl (
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire logic                         halt_req,
  input  wire logic                         nmi_req,
  input  wire logic                         external_irq_zero,
  input  wire logic                         irq_zero_masked,
  input  wire logic                         periph_irq,
  input  wire logic                         cur_slow_mode,
  input  wire smwc_pkg::smwc_cfg_t          cfg,
  input  wire logic [smwc_pkg::PORT_W-1:0]  port_out,
  input  wire logic [smwc_pkg::PORT_W-1:0]  port_oe,
  input  wire logic                         ale_run,
  input  wire logic                         clk_run,
  output smwc_pkg::smwc_clk_t               clk_ctrl,
  output logic                              stopped,
  output logic                              resume,
  output logic                              skip_service,
  output logic                              wake_pending,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_out,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_oe,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_in_gate,
  output logic      [smwc_pkg::PORT_W-1:0]  pin_pull_en,
  output logic                              ale_out,
  output logic                              clkout_out,
  output logic                              clkout_oe,
  output logic                              xtal_out
);
  logic                            rst_meta_q;
  logic                            rst_n_q;
  smwc_pkg::smwc_state_t           state_q;
  logic [3:0]                      exec_cnt_q;
  logic [1:0]                      entry_cnt_q;
  logic                            pend_q;
  logic                            masked_q;
  logic                            warm_start;
  logic                            warm_done;
  logic                            wake;
  logic [smwc_pkg::WARM_CNT_W-1:0] warm_limit;
  logic [smwc_pkg::WARM_CNT_W-1:0] warm_cyc_q;

  // reset release through two flops; reset also ends stop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // only the two external wake sources count; peripheral irqs ignored
  assign wake = nmi_req | external_irq_zero;
  // a held entry wake does not wake by itself; a fresh wake is needed
  assign warm_start = (state_q == smwc_pkg::SMWC_STOP) && wake;

  // warm-up length selection
  always_comb begin
    if (cfg.fast_warmup_select) begin
      warm_limit = smwc_pkg::WARM_FAST_CNT;
    end else if (cfg.warm_select) begin
      warm_limit = smwc_pkg::WARM_LONG_CNT;
    end else begin
      warm_limit = smwc_pkg::WARM_SHORT_CNT;
    end
  end

  // sequencing of halt, entry, stop and warm-up
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q     <= smwc_pkg::SMWC_RUN;
      exec_cnt_q  <= '0;
      entry_cnt_q <= '0;
    end else begin
      case (state_q)
        smwc_pkg::SMWC_RUN: begin
          if (halt_req) begin
            state_q    <= smwc_pkg::SMWC_HALT;
            exec_cnt_q <= smwc_pkg::HALT_EXEC_STATES - 4'h1;
          end
        end
        smwc_pkg::SMWC_HALT: begin
          if (wake) begin
            state_q <= smwc_pkg::SMWC_RUN;
          end else if (exec_cnt_q == '0) begin
            state_q     <= smwc_pkg::SMWC_ENTRY;
            entry_cnt_q <= smwc_pkg::ENTRY_CLOCKS - 2'h1;
          end else begin
            exec_cnt_q <= exec_cnt_q - 4'h1;
          end
        end
        smwc_pkg::SMWC_ENTRY: begin
          if (entry_cnt_q == '0) begin
            state_q <= smwc_pkg::SMWC_STOP;
          end else begin
            entry_cnt_q <= entry_cnt_q - 2'h1;
          end
        end
        smwc_pkg::SMWC_STOP: begin
          if (warm_start) begin
            state_q <= smwc_pkg::SMWC_WARM;
          end
        end
        smwc_pkg::SMWC_WARM: begin
          if (warm_done) begin
            state_q <= smwc_pkg::SMWC_RUN;
          end
        end
        default: state_q <= smwc_pkg::SMWC_RUN;
      endcase
    end
  end

  // wake during entry is held pending; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= 1'b0;
    end else if (state_q == smwc_pkg::SMWC_ENTRY && wake) begin
      pend_q <= 1'b1;
    end else if (state_q == smwc_pkg::SMWC_STOP && wake) begin
      pend_q <= 1'b0;
    end
  end

  // remember a masked irq zero wake
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      masked_q <= 1'b0;
    end else if (warm_start) begin
      masked_q <= external_irq_zero && !nmi_req && irq_zero_masked;
    end
  end

  // cycles spent in warm-up, counted apart from the counter so the length
  // checks below do not lean on the logic they judge
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      warm_cyc_q <= '0;
    end else if (warm_start) begin
      warm_cyc_q <= '0;
    end else if (state_q == smwc_pkg::SMWC_WARM) begin
      warm_cyc_q <= warm_cyc_q + 17'h00001;
    end
  end

  smwc_warm_counter u_warm (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_q),
    .start   (warm_start),
    .limit   (warm_limit),
    .done    (warm_done)
  );

  // clock gating and status outputs
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_ctrl     <= '{osc_main_en: 1'b1, osc_sub_en: 1'b0, sys_clk_en: 1'b1, slow_mode: 1'b0};
      stopped      <= 1'b0;
      resume       <= 1'b0;
      skip_service <= 1'b0;
      wake_pending <= 1'b0;
    end else begin
      resume       <= 1'b0;
      skip_service <= 1'b0;
      wake_pending <= pend_q;
      case (state_q)
        smwc_pkg::SMWC_STOP: begin
          clk_ctrl.osc_main_en <= warm_start;
          clk_ctrl.osc_sub_en  <= 1'b0;
          clk_ctrl.sys_clk_en  <= 1'b0;
          stopped              <= !warm_start;
        end
        smwc_pkg::SMWC_WARM: begin
          clk_ctrl.osc_main_en <= cfg.main_osc_return_enable | !cfg.return_clock_select;
          clk_ctrl.osc_sub_en  <= cfg.sub_osc_return_enable | cfg.return_clock_select;
          clk_ctrl.sys_clk_en  <= warm_done;
          stopped              <= 1'b0;
          if (warm_done) begin
            clk_ctrl.slow_mode <= cfg.return_clock_select;
            resume             <= 1'b1;
            skip_service       <= masked_q;
          end
        end
        smwc_pkg::SMWC_ENTRY: begin
          clk_ctrl.sys_clk_en <= 1'b0;
          stopped             <= 1'b0;
        end
        default: begin
          clk_ctrl.sys_clk_en <= 1'b1;
          clk_ctrl.slow_mode  <= (state_q == smwc_pkg::SMWC_RUN) ? cur_slow_mode : clk_ctrl.slow_mode;
          stopped             <= 1'b0;
        end
      endcase
    end
  end

  smwc_pin_ctrl u_pins (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n_q),
    .stopped      (stopped),
    .drive_enable (cfg.drive_enable),
    .port_out     (port_out),
    .port_oe      (port_oe),
    .ale_run      (ale_run),
    .clk_run      (clk_run),
    .pin_out      (pin_out),
    .pin_oe       (pin_oe),
    .pin_in_gate  (pin_in_gate),
    .pin_pull_en  (pin_pull_en),
    .ale_out      (ale_out),
    .clkout_out   (clkout_out),
    .clkout_oe    (clkout_oe),
    .xtal_out     (xtal_out)
  );

  // stop entry, halt abandon and clock gating checks
  a_stop_no_clk: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    stopped |-> !clk_ctrl.sys_clk_en && !clk_ctrl.osc_main_en && !clk_ctrl.osc_sub_en)
    else $error("clock runs in stop");
  a_entry_clk: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    state_q == smwc_pkg::SMWC_ENTRY |=> !clk_ctrl.sys_clk_en)
    else $error("clock runs during entry");
  a_halt_len: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_RUN && halt_req) ##1 (!wake) [*8] |=> state_q == smwc_pkg::SMWC_ENTRY)
    else $error("halt execution length wrong");
  a_halt_abandon: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_HALT && wake) |=> state_q == smwc_pkg::SMWC_RUN && !stopped)
    else $error("halt not abandoned");
  a_halt_no_mode: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_HALT && wake) |=> clk_ctrl.slow_mode == $past(clk_ctrl.slow_mode))
    else $error("mode switched on abandon");
  a_entry_len: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    $rose(state_q == smwc_pkg::SMWC_ENTRY) |-> ##3 state_q == smwc_pkg::SMWC_STOP)
    else $error("entry length wrong");

  // wake source and pending checks
  a_periph_no_wake: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_STOP && !nmi_req && !external_irq_zero && periph_irq)
    |=> state_q == smwc_pkg::SMWC_STOP) else $error("peripheral woke stop");
  a_wake_starts: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_STOP && wake) |=> state_q == smwc_pkg::SMWC_WARM) else $error("wake ignored");
  a_entry_pend: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_ENTRY && wake) |=> pend_q) else $error("entry wake lost");
  a_pend_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (state_q == smwc_pkg::SMWC_STOP && pend_q && !wake) |=> state_q == smwc_pkg::SMWC_STOP)
    else $error("held wake left stop");
  a_pend_show: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    pend_q |=> wake_pending) else $error("held wake not shown");

  // warm-up length and resume checks
  a_warm_short: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (warm_done && !cfg.fast_warmup_select && !cfg.warm_select) |-> warm_cyc_q == smwc_pkg::WARM_SHORT_CNT)
    else $error("short warm-up length");
  a_warm_long: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (warm_done && !cfg.fast_warmup_select && cfg.warm_select) |-> warm_cyc_q == smwc_pkg::WARM_LONG_CNT)
    else $error("long warm-up length");
  a_warm_fast: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (warm_start && cfg.fast_warmup_select) |-> ##18 state_q == smwc_pkg::SMWC_RUN)
    else $error("fast warm-up length");
  a_warm_clk_off: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    warm_start |=> !clk_ctrl.sys_clk_en [*8]) else $error("clock early in warm-up");
  a_warm_osc_on: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    state_q == smwc_pkg::SMWC_WARM |-> clk_ctrl.osc_main_en || clk_ctrl.osc_sub_en)
    else $error("oscillator off in warm-up");
  a_resume_clk: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    resume |-> clk_ctrl.sys_clk_en && !stopped) else $error("resume without clock");
  a_return_sel: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    resume |-> clk_ctrl.slow_mode == $past(cfg.return_clock_select))
    else $error("return clock wrong");

  // pin state checks during stop
  a_pin_float: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    (stopped && !cfg.drive_enable) |=> pin_oe == '0 && pin_in_gate == '0 && pin_pull_en == '1)
    else $error("pins driven in stop");
  a_ale_low: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    $past(stopped) |-> !ale_out && xtal_out && clkout_oe == $past(cfg.drive_enable))
    else $error("stop pins wrong");
  a_clkout_high: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
    ($past(stopped) && $past(cfg.drive_enable)) |-> clkout_out)
    else $error("clock pin not high in stop");

  // cover points for the main scenarios
  c_full_stop: cover property (@(posedge ref_clk) disable iff (!rst_n_q) resume);
  c_abandon: cover property (@(posedge ref_clk) disable iff (!rst_n_q) state_q == smwc_pkg::SMWC_HALT && wake);
  c_pending: cover property (@(posedge ref_clk) disable iff (!rst_n_q) pend_q && state_q == smwc_pkg::SMWC_STOP);
  c_skip: cover property (@(posedge ref_clk) disable iff (!rst_n_q) skip_service);
  c_long_warm: cover property (@(posedge ref_clk) disable iff (!rst_n_q) warm_done && cfg.warm_select);
endmodule // smwc_stop_ctrl
`default_nettype wire

//--- dv/smwc_wake_src.sv
`timescale 1ns/1ps
`default_nettype none
// wake pin model: raises a pin lag cycles after its command and holds it while commanded
module smwc_wake_src (
  input  wire logic       ref_clk,
  input  wire logic       cmd_nmi,
  input  wire logic       cmd_irq0,
  input  wire logic [3:0] lag,
  output logic            nmi_req,
  output logic            external_irq_zero
);
  logic [3:0] cnt_q;

  // delay counter, cleared whenever no command is given
  always_ff @(posedge ref_clk) begin
    if (!(cmd_nmi | cmd_irq0)) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != lag) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // level held high while commanded, as a slow or prompt source
  always_comb begin
    nmi_req           = cmd_nmi & (cnt_q == lag);
    external_irq_zero = cmd_irq0 & (cnt_q == lag);
  end
endmodule // smwc_wake_src
`default_nettype wire

//--- dv/stop_mode_wakeup_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stop_mode_wakeup_control_tb;
  logic                 ref_clk, rstn, halt_req, irq_zero_masked, periph_irq, cur_slow_mode;
  logic                 ale_run, clk_run, cmd_nmi, cmd_irq0, nmi_req, external_irq_zero;
  logic [3:0]           lag;
  logic [7:0]           port_out, port_oe, pin_out, pin_oe, pin_in_gate, pin_pull_en;
  logic                 stopped, resume, skip_service, wake_pending;
  logic                 ale_out, clkout_out, clkout_oe, xtal_out;
  smwc_pkg::smwc_cfg_t  cfg;
  smwc_pkg::smwc_clk_t  clk_ctrl;
  int                   err_count, num_checks, cyc;

  smwc_stop_ctrl dut_u (.ref_clk(ref_clk), .rstn(rstn), .halt_req(halt_req), .nmi_req(nmi_req),
    .external_irq_zero(external_irq_zero), .irq_zero_masked(irq_zero_masked), .periph_irq(periph_irq),
    .cur_slow_mode(cur_slow_mode), .cfg(cfg), .port_out(port_out), .port_oe(port_oe), .ale_run(ale_run),
    .clk_run(clk_run), .clk_ctrl(clk_ctrl), .stopped(stopped), .resume(resume), .skip_service(skip_service),
    .wake_pending(wake_pending), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_gate(pin_in_gate),
    .pin_pull_en(pin_pull_en), .ale_out(ale_out), .clkout_out(clkout_out), .clkout_oe(clkout_oe),
    .xtal_out(xtal_out));

  smwc_wake_src wake_u (.ref_clk(ref_clk), .cmd_nmi(cmd_nmi), .cmd_irq0(cmd_irq0), .lag(lag),
    .nmi_req(nmi_req), .external_irq_zero(external_irq_zero));

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one-cycle halt request, taken at the second edge
  task automatic do_halt;
    @(posedge ref_clk);
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
  endtask

  task automatic wait_lvl(input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (stopped !== v && n < lim);
  endtask

  // full stop, wake and warm-up with one setting
  task automatic t_stop(input logic de, wm, fw, rcs, irq, msk, input int lim);
    int n;
    cfg <= '{de, wm, fw, rcs, 1'b1, 1'b1};
    irq_zero_masked <= msk;
    lag <= irq ? 4'h5 : 4'h0;
    do_halt();
    wait_lvl(1'b1, 40, n);
    chk("entry_len", 17'h1, 17'(n >= 11 && n <= 13));
    step(2);
    #1;
    chk("osc_clk_off", 17'h0, {clk_ctrl.osc_main_en, clk_ctrl.osc_sub_en, clk_ctrl.sys_clk_en});
    chk("pin_oe", 17'(de ? port_oe : 8'h00), pin_oe);
    chk("pin_in_gate", 17'(de ? 8'hFF : 8'h00), pin_in_gate);
    chk("pin_pull_en", 17'(de ? 8'h00 : 8'hFF), pin_pull_en);
    if (de) chk("pin_out", 17'(port_out), pin_out);
    chk("ale_xtal_ckoe", {14'h0, 1'b0, 1'b1, de}, {ale_out, xtal_out, clkout_oe});
    if (de) chk("clkout", 17'h1, clkout_out);
    step(1);
    periph_irq <= 1'b1;
    step(20);
    #1;
    chk("periph_no_wake", 17'h1, stopped);
    step(1);
    periph_irq <= 1'b0;
    if (irq) cmd_irq0 <= 1'b1;
    else cmd_nmi <= 1'b1;
    wait_lvl(1'b0, 20, n);
    chk("woke", 17'h0, stopped);
    n = 1;
    @(posedge ref_clk);
    #1;
    chk("warm_hold", 17'h2, {clk_ctrl.osc_main_en, clk_ctrl.sys_clk_en});
    while (resume !== 1'b1 && n < 70000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("warm_len", 17'h1, 17'(n >= lim && n <= lim + 4));
    chk("skip_service", 17'(irq & msk), skip_service);
    chk("return_mode", {15'h0, 1'b1, rcs}, {clk_ctrl.sys_clk_en, clk_ctrl.slow_mode});
    step(1);
    cmd_nmi <= 1'b0;
    cmd_irq0 <= 1'b0;
  endtask

  // wake during halt execution: no stop, mode kept
  task automatic t_abort;
    int n;
    cur_slow_mode <= 1'b1;
    cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    do_halt();
    step(3);
    cmd_nmi <= 1'b1;
    wait_lvl(1'b1, 20, n);
    chk("abort_no_stop", 17'h0, stopped);
    chk("abort_mode", 17'h3, {clk_ctrl.sys_clk_en, clk_ctrl.slow_mode});
    step(1);
    cmd_nmi <= 1'b0;
    cur_slow_mode <= 1'b0;
    step(4);
  endtask

  // wake pulse in the entry window is held pending
  task automatic t_pending;
    int n;
    cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    do_halt();
    step(9);
    cmd_nmi <= 1'b1;
    step(1);
    cmd_nmi <= 1'b0;
    wait_lvl(1'b1, 40, n);
    step(2);
    #1;
    chk("pending_set", 17'h3, {wake_pending, stopped});
    step(1);
    cmd_nmi <= 1'b1;
    n = 0;
    while (resume !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("pending_wake", 17'h1, resume);
    step(1);
    cmd_nmi <= 1'b0;
    #1;
    chk("pending_clr", 17'h0, wake_pending);
  endtask

  // system reset in stop ends it and restores defaults
  task automatic t_reset;
    int n;
    do_halt();
    wait_lvl(1'b1, 40, n);
    step(1);
    rstn <= 1'b0;
    step(2);
    #1;
    chk("rst_stop", 17'h0, stopped);
    chk("rst_clk", 17'h6, {clk_ctrl.osc_main_en, clk_ctrl.sys_clk_en, clk_ctrl.slow_mode});
    step(1);
    rstn <= 1'b1;
    step(4);
  endtask

  // cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      conclude();
    end
  end

  // main sequence
  initial begin
    {rstn, halt_req, irq_zero_masked, periph_irq, cur_slow_mode, cmd_nmi, cmd_irq0} = 7'h00;
    {ale_run, clk_run, lag, port_out, port_oe} = {2'h3, 4'h0, 8'hA5, 8'h3C};
    cfg = '0;
    {err_count, num_checks, cyc} = '0;
    step(6);
    rstn <= 1'b1;
    step(3);
    t_stop(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, int'(smwc_pkg::WARM_SHORT_CNT));
    t_stop(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, int'(smwc_pkg::WARM_LONG_CNT));
    t_stop(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, int'(smwc_pkg::WARM_FAST_CNT));
    t_stop(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, int'(smwc_pkg::WARM_FAST_CNT));
    t_abort();
    t_pending();
    t_reset();
    conclude();
  end
endmodule // stop_mode_wakeup_control_tb
`default_nettype wire
